// [src/qdac_pkg.sv]
// Shared constants and types of the quad converter register control.
package qdac_pkg;
	localparam int          FRAME_BITS       = 24;
	localparam int          CHANNELS         = 4;
	localparam int          CODE_W           = 14;
	localparam int          OFFSET_W         = 9;
	localparam int          FRAC_W           = 5;
	localparam int          LEVEL_W          = 21;
	localparam int          CNT_W            = 5;
	localparam int          FRAME_READ_BIT   = 23;
	localparam int          FRAME_ADDR_LSB   = 16;
	localparam logic [3:0]  ADDR_COMMAND     = 4'h0;
	localparam logic [3:0]  ADDR_MONITOR     = 4'h1;
	localparam logic [1:0]  ADDR_DATA_GROUP  = 2'h1;
	localparam logic [1:0]  ADDR_ZERO_GROUP  = 2'h2;
	localparam int          CMD_READ_LATCH   = 15;
	localparam int          CMD_UPDATE       = 14;
	localparam int          CMD_SOFT_RESET   = 13;
	localparam int          CMD_SDO_DISABLE  = 7;
	localparam int          CMD_NO_EFFECT    = 6;
	localparam int          CMD_RANGE_LSB    = 2;
	localparam int          MON_SEL_LSB      = 11;
	localparam int          CODE_LSB         = 2;
	localparam logic        SDO_DIS_RESET    = 1'b0;
	localparam logic        READ_LATCH_RESET = 1'b0;
	localparam logic [3:0]  RANGE_RESET      = 4'hf;
	localparam logic [4:0]  MONITOR_RESET    = 5'h00;
	localparam logic [13:0] CODE_RESET       = 14'h0000;
	localparam logic [8:0]  OFFSET_RESET     = 9'h000;

	typedef enum logic [1:0] {
		RD_INPUT,
		RD_LATCH,
		RD_ZERO
	} qdac_rd_src_type;
endpackage

// [src/qdac_chan_if.sv]
// Carrier between the register control and its channel store and level stage.
`timescale 1ns/10ps
`default_nettype none
interface qdac_chan_if;
	logic                          wr_data_en;
	logic                          wr_zero_en;
	logic [1:0]                    wr_chan;
	logic [15:0]                   wr_word;
	logic                          update;
	logic                          soft_clear;
	logic [1:0]                    rd_chan;
	qdac_pkg::qdac_rd_src_type     rd_src;
	logic [15:0]                   rd_word;
	logic [qdac_pkg::CODE_W-1:0]   latch_code [qdac_pkg::CHANNELS];
	logic [qdac_pkg::OFFSET_W-1:0] zero_trim [qdac_pkg::CHANNELS];

	modport ctl (output wr_data_en, wr_zero_en, wr_chan, wr_word, update, soft_clear,
		rd_chan, rd_src, input rd_word);
	modport mem (input wr_data_en, wr_zero_en, wr_chan, wr_word, update, soft_clear,
		rd_chan, rd_src, output rd_word, latch_code, zero_trim);
	modport view (input latch_code, zero_trim);
endinterface
`default_nettype wire

// [src/qdac_chan_store.sv]
// Per-channel input data, output latch and zero trim storage.
`timescale 1ns/10ps
`default_nettype none
module qdac_chan_store
(
	input  wire logic clock_in,
	input  wire logic resetn_in,
	qdac_chan_if.mem  bus
);
	logic [qdac_pkg::CODE_W-1:0]   input_code [qdac_pkg::CHANNELS];
	logic                          dirty [qdac_pkg::CHANNELS];

	genvar c;
	generate
		for (c = 0; c < qdac_pkg::CHANNELS; c++)
		begin : g_chan
			wire hit_data = bus.wr_data_en && (bus.wr_chan == 2'(c));
			wire hit_zero = bus.wr_zero_en && (bus.wr_chan == 2'(c));
			always_ff @(posedge clock_in or negedge resetn_in)
			begin
				if (!resetn_in)
				begin
					input_code[c]     <= qdac_pkg::CODE_RESET;
					bus.latch_code[c] <= qdac_pkg::CODE_RESET;
					bus.zero_trim[c]  <= qdac_pkg::OFFSET_RESET;
					dirty[c]          <= 1'b0;
				end
				else if (bus.soft_clear)
				begin
					input_code[c]     <= qdac_pkg::CODE_RESET;
					bus.latch_code[c] <= qdac_pkg::CODE_RESET;
					bus.zero_trim[c]  <= qdac_pkg::OFFSET_RESET;
					dirty[c]          <= 1'b0;
				end
				else
				begin
					if (hit_data)
						input_code[c] <= bus.wr_word[15:qdac_pkg::CODE_LSB];
					if (hit_zero)
						bus.zero_trim[c] <= bus.wr_word[qdac_pkg::OFFSET_W-1:0];
					if (bus.update && dirty[c])
						bus.latch_code[c] <= input_code[c];
					dirty[c] <= hit_data || (dirty[c] && !bus.update);
				end
			end
		end
	endgenerate

	wire [15:0] sel_word = (bus.rd_src == qdac_pkg::RD_LATCH) ?
		{bus.latch_code[bus.rd_chan], 2'b00} :
		(bus.rd_src == qdac_pkg::RD_ZERO) ? {7'h00, bus.zero_trim[bus.rd_chan]} :
		{input_code[bus.rd_chan], 2'b00};

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
			bus.rd_word <= 16'h0000;
		else
			bus.rd_word <= sel_word;
	end
endmodule
`default_nettype wire

// [src/qdac_level.sv]
// Per-channel output level in steps of a thirty-second of a code step.
`timescale 1ns/10ps
`default_nettype none
module qdac_level
(
	input  wire logic                   clock_in,
	input  wire logic                   resetn_in,
	input  wire logic                   bipolar_in,
	qdac_chan_if.view                   bus,
	output logic [4*qdac_pkg::LEVEL_W-1:0] level_out
);
	logic [qdac_pkg::LEVEL_W-1:0] next_level [qdac_pkg::CHANNELS];

	genvar c;
	generate
		for (c = 0; c < qdac_pkg::CHANNELS; c++)
		begin : g_lvl
			wire [qdac_pkg::CODE_W-1:0] code = bus.latch_code[c];
			wire [qdac_pkg::OFFSET_W-1:0] trim = bus.zero_trim[c];
			wire signed [qdac_pkg::LEVEL_W-1:0] scaled = bipolar_in ?
				$signed({{2{code[13]}}, code, 5'b00000}) :
				$signed({2'b00, code, 5'b00000});
			wire signed [qdac_pkg::LEVEL_W-1:0] offset =
				$signed({{12{trim[8]}}, trim});
			assign next_level[c] = scaled + offset;
		end
	endgenerate

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
			level_out <= '0;
		else
			for (int k = 0; k < qdac_pkg::CHANNELS; k++)
				level_out[k*qdac_pkg::LEVEL_W +: qdac_pkg::LEVEL_W] <= next_level[k];
	end
endmodule
`default_nettype wire

// [src/qdac_ctrl.sv]
// Serial register control for a four-channel converter.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Output-disable bit 7 set keeps serial output high-impedance always; clear means normal.
// - No-effect bit 6 ignores writes, clears after each write, reads zero.
// - Command bits 5..2 pick gain four (1) or two (0) for channels 3..0.
// - Command bits 1 and 0 ignore writes and read zero.
// - Monitor bits 11..15 select aux input, then channels 0 to 3.
// - No select bit set disables monitor, output high-impedance; resets to zero.
// - Reserved monitor and data register bits ignore writes and read zero.
// - Input data registers reset to zero; data writes move output only after latch transfer.
// - Channel code sits in bits 15..2, most significant at bit 15.
// - Bipolar codes are two's complement, unipolar codes straight binary.
// - Bipolar output is half gain times reference times signed code over 8192.
// - Unipolar output is gain times reference times code over 16384.
// - Each channel has a nine-bit zero trim in thirty-second code steps.
// - Zero trim is two's complement in both modes.
// - All zero trim registers reset to zero.
// - Update by pin or bit loads only channels written since last update.
// - Data readback gives input register, or output latch when source bit set.
module qdac_ctrl
(
	input  wire logic                          clock_in,
	input  wire logic                          resetn_in,
	input  wire logic                          sclk_in,
	input  wire logic                          cs_n_in,
	input  wire logic                          sdi_in,
	input  wire logic                          latch_load_pin_n_in,
	input  wire logic                          bipolar_in,
	output logic                               sdo_out,
	output logic                               sdo_oe_out,
	output logic [3:0]                         range_x4_out,
	output logic [4:0]                         monitor_sel_out,
	output logic                               monitor_oe_out,
	output logic [4*qdac_pkg::LEVEL_W-1:0]     level_out
);
	qdac_chan_if chan ();

	logic                            sclk_q;
	logic                            sclk_prev;
	logic                            cs_n_q;
	logic                            cs_n_prev;
	logic                            sdi_q;
	logic                            load_n_q;
	logic                            load_n_prev;
	logic [qdac_pkg::FRAME_BITS-1:0] rx_shift;
	logic [qdac_pkg::FRAME_BITS-1:0] tx_shift;
	logic [qdac_pkg::CNT_W-1:0]      bit_count;
	logic                            serial_out_disable;
	logic                            read_latch;
	logic                            rd_pending;
	logic                            rd_is_cmd;
	logic                            rd_is_mon;
	logic                            soft_clear;

	wire sclk_rise  = sclk_q && !sclk_prev && !cs_n_q;
	wire sclk_fall  = !sclk_q && sclk_prev && !cs_n_q;
	wire frame_end  = cs_n_q && !cs_n_prev;
	wire frame_ok   = frame_end && (bit_count == 5'(qdac_pkg::FRAME_BITS));
	wire is_read    = rx_shift[qdac_pkg::FRAME_READ_BIT];
	wire [3:0] addr = rx_shift[qdac_pkg::FRAME_ADDR_LSB +: 4];
	wire [15:0] word = rx_shift[15:0];
	wire do_write   = frame_ok && !is_read;
	wire wr_cmd     = do_write && (addr == qdac_pkg::ADDR_COMMAND);
	wire wr_mon     = do_write && (addr == qdac_pkg::ADDR_MONITOR);
	wire data_addr  = (addr[3:2] == qdac_pkg::ADDR_DATA_GROUP);
	wire zero_addr  = (addr[3:2] == qdac_pkg::ADDR_ZERO_GROUP);
	wire pin_update = load_n_prev && !load_n_q;
	wire bit_update = wr_cmd && word[qdac_pkg::CMD_UPDATE] && load_n_q;
	wire sw_reset   = wr_cmd && word[qdac_pkg::CMD_SOFT_RESET];

	wire [15:0] cmd_word = {read_latch, 7'h00, serial_out_disable, 1'b0,
		range_x4_out, 2'b00};
	wire [15:0] mon_word = {monitor_sel_out, 11'h000};
	wire [15:0] rd_mux   = rd_is_cmd ? cmd_word : rd_is_mon ? mon_word : chan.rd_word;

	assign chan.wr_data_en = do_write && data_addr;
	assign chan.wr_zero_en = do_write && zero_addr;
	assign chan.wr_chan    = addr[1:0];
	assign chan.wr_word    = word;
	assign chan.update     = pin_update || bit_update;
	assign chan.soft_clear = soft_clear;
	assign chan.rd_chan    = addr[1:0];
	assign chan.rd_src     = zero_addr ? qdac_pkg::RD_ZERO :
		read_latch ? qdac_pkg::RD_LATCH : qdac_pkg::RD_INPUT;

	qdac_chan_store u_store
	(
		.clock_in  (clock_in),
		.resetn_in (resetn_in),
		.bus       (chan.mem)
	);

	qdac_level u_level
	(
		.clock_in   (clock_in),
		.resetn_in  (resetn_in),
		.bipolar_in (bipolar_in),
		.bus        (chan.view),
		.level_out  (level_out)
	);

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sclk_q      <= 1'b0;
			sclk_prev   <= 1'b0;
			cs_n_q      <= 1'b1;
			cs_n_prev   <= 1'b1;
			sdi_q       <= 1'b0;
			load_n_q    <= 1'b1;
			load_n_prev <= 1'b1;
		end
		else
		begin
			sclk_q      <= sclk_in;
			sclk_prev   <= sclk_q;
			cs_n_q      <= cs_n_in;
			cs_n_prev   <= cs_n_q;
			sdi_q       <= sdi_in;
			load_n_q    <= latch_load_pin_n_in;
			load_n_prev <= load_n_q;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rx_shift  <= '0;
			bit_count <= '0;
		end
		else if (frame_end)
			bit_count <= '0;
		else if (sclk_rise)
		begin
			rx_shift  <= {rx_shift[qdac_pkg::FRAME_BITS-2:0], sdi_q};
			bit_count <= (bit_count == 5'(qdac_pkg::FRAME_BITS)) ? bit_count : bit_count + 5'd1;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
			tx_shift <= '0;
		else if (rd_pending)
			tx_shift <= {8'h00, rd_mux};
		else if (sclk_fall)
			tx_shift <= {tx_shift[qdac_pkg::FRAME_BITS-2:0], 1'b0};
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rd_pending <= 1'b0;
			rd_is_cmd  <= 1'b0;
			rd_is_mon  <= 1'b0;
		end
		else
		begin
			rd_pending <= frame_ok && is_read;
			rd_is_cmd  <= addr == qdac_pkg::ADDR_COMMAND;
			rd_is_mon  <= addr == qdac_pkg::ADDR_MONITOR;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
			soft_clear <= 1'b0;
		else
			soft_clear <= sw_reset;
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			serial_out_disable <= qdac_pkg::SDO_DIS_RESET;
			read_latch         <= qdac_pkg::READ_LATCH_RESET;
			range_x4_out       <= qdac_pkg::RANGE_RESET;
		end
		else if (soft_clear)
		begin
			serial_out_disable <= qdac_pkg::SDO_DIS_RESET;
			read_latch         <= qdac_pkg::READ_LATCH_RESET;
			range_x4_out       <= qdac_pkg::RANGE_RESET;
		end
		else if (wr_cmd)
		begin
			serial_out_disable <= word[qdac_pkg::CMD_SDO_DISABLE];
			read_latch         <= word[qdac_pkg::CMD_READ_LATCH];
			range_x4_out       <= word[qdac_pkg::CMD_RANGE_LSB +: 4];
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			monitor_sel_out <= qdac_pkg::MONITOR_RESET;
			monitor_oe_out  <= 1'b0;
		end
		else if (soft_clear)
		begin
			monitor_sel_out <= qdac_pkg::MONITOR_RESET;
			monitor_oe_out  <= 1'b0;
		end
		else if (wr_mon)
		begin
			monitor_sel_out <= word[qdac_pkg::MON_SEL_LSB +: 5];
			monitor_oe_out  <= |word[qdac_pkg::MON_SEL_LSB +: 5];
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sdo_out    <= 1'b0;
			sdo_oe_out <= 1'b0;
		end
		else
		begin
			sdo_out    <= tx_shift[qdac_pkg::FRAME_BITS-1];
			sdo_oe_out <= !serial_out_disable && !cs_n_q;
		end
	end
endmodule
`default_nettype wire

// [tb/qdac_ctrl_properties.sv]
// Concurrent checks on the ports of the quad converter register control.
`timescale 1ns/10ps
`default_nettype none
module qdac_ctrl_properties
(
	input wire logic                           clock_in,
	input wire logic                           resetn_in,
	input wire logic                           cs_n_in,
	input wire logic                           latch_load_pin_n_in,
	input wire logic                           bipolar_in,
	input wire logic                           sdo_oe_out,
	input wire logic [3:0]                     range_x4_out,
	input wire logic [4:0]                     monitor_sel_out,
	input wire logic                           monitor_oe_out,
	input wire logic [4*qdac_pkg::LEVEL_W-1:0] level_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	sequence in_frame;
		!cs_n_in [*3];
	endsequence
	sequence quiet;
		(!cs_n_in && latch_load_pin_n_in && $stable(bipolar_in)) [*6];
	endsequence
	reset_values_a: assert property (
		$rose(resetn_in) |-> range_x4_out == 4'hf && monitor_sel_out == 5'h00 && level_out == '0)
		else $error("outputs not at reset values");
	mon_enable_a: assert property (
		monitor_oe_out == (monitor_sel_out != 5'h00))
		else $error("monitor enable disagrees with select");
	sdo_idle_a: assert property (
		cs_n_in [*3] |-> !sdo_oe_out)
		else $error("serial output driven while deselected");
	sdo_rise_a: assert property (
		$rose(sdo_oe_out) |-> !$past(cs_n_in) || !$past(cs_n_in, 2))
		else $error("serial output enabled without select");
	frame_hold_a: assert property (
		in_frame |=> $stable(range_x4_out) && $stable(monitor_sel_out))
		else $error("settings moved inside a frame");
	range_after_a: assert property (
		$changed(range_x4_out) |-> cs_n_in && $past(cs_n_in) && $past(cs_n_in, 2))
		else $error("range moved before frame end");
	mon_after_a: assert property (
		$changed(monitor_sel_out) |-> cs_n_in && $past(cs_n_in) && $past(cs_n_in, 2))
		else $error("monitor moved before frame end");
	level_hold_a: assert property (
		quiet |=> $stable(level_out))
		else $error("level moved without update");
endmodule
bind qdac_ctrl qdac_ctrl_properties props (.clock_in, .resetn_in, .cs_n_in,
	.latch_load_pin_n_in, .bipolar_in, .sdo_oe_out, .range_x4_out,
	.monitor_sel_out, .monitor_oe_out, .level_out);
`default_nettype wire

// [tb/qdac_host.sv]
// Host model that runs serial frames into the register control.
`timescale 1ns/10ps
`default_nettype none
module qdac_host
(
	input  wire logic clock_in,
	input  wire logic sdo_in,
	input  wire logic sdo_oe_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      sdi_out
);
	logic oe_seen = 1'b0;
	initial
	begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
	end
	// Clock idles low; data is set while low and held until after the rise.
	task automatic xfer(input logic [23:0] w, output logic [23:0] r);
		oe_seen = 1'b0;
		@(posedge clock_in) cs_n_out <= 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			@(posedge clock_in) sdi_out <= w[i];
			repeat (4) @(posedge clock_in);
			r[i] = sdo_oe_in ? sdo_in : ~sdo_in;
			oe_seen = oe_seen | sdo_oe_in;
			sclk_out <= 1'b1;
			repeat (4) @(posedge clock_in);
			sclk_out <= 1'b0;
		end
		repeat (4) @(posedge clock_in);
		cs_n_out <= 1'b1;
		sdi_out <= ~sdi_out;
		repeat (6) @(posedge clock_in);
	endtask
endmodule
`default_nettype wire

// [tb/qdac_ctrl_bench.sv]
// Self-checking bench for the quad converter register control.
`timescale 1ns/10ps
`default_nettype none
module qdac_ctrl_bench;
	logic        clock_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        latch_load_pin_n_in = 1'b1;
	logic        bipolar_in = 1'b0;
	logic        sclk_in, cs_n_in, sdi_in, sdo_out, sdo_oe_out, monitor_oe_out;
	logic [3:0]  range_x4_out;
	logic [4:0]  monitor_sel_out;
	logic [83:0] level_out;
	logic [13:0] lat [4] = '{default: 14'h0000};
	logic [13:0] nw [4];
	logic [8:0]  zt [4] = '{default: 9'h000};
	logic [13:0] code;
	logic [3:0]  r4;
	logic [4:0]  v;
	logic [15:0] d;
	int          errors = 0;
	int          samples_checked = 0;
	always #12.5 clock_in = ~clock_in;
	qdac_host host (.clock_in(clock_in), .sdo_in(sdo_out), .sdo_oe_in(sdo_oe_out),
		.sclk_out(sclk_in), .cs_n_out(cs_n_in), .sdi_out(sdi_in));
	qdac_ctrl uut (.clock_in, .resetn_in, .sclk_in, .cs_n_in, .sdi_in, .latch_load_pin_n_in,
		.bipolar_in, .sdo_out, .sdo_oe_out, .range_x4_out, .monitor_sel_out,
		.monitor_oe_out, .level_out);
	function automatic logic [20:0] lvl(logic [13:0] c, logic [8:0] z, logic b);
		return {{2{b & c[13]}}, c, 5'h00} + {{12{z[8]}}, z};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] w);
		logic [23:0] r;
		host.xfer({4'h0, a, w}, r);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] q);
		logic [23:0] r;
		host.xfer({4'h8, a, 16'h0000}, r);
		host.xfer({4'h0, 4'h2, 16'h0000}, r);
		q = r[15:0];
	endtask
	task automatic levels;
		for (int n = 0; n < 4; n++)
			chk(level_out[21*n +: 21], lvl(lat[n], zt[n], bipolar_in), "level");
	endtask
	task tally_and_finish;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		void'($urandom(73104));
		repeat (3) @(posedge clock_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		chk(range_x4_out, 4'hf, "range reset");
		chk({monitor_oe_out, monitor_sel_out}, 6'h00, "monitor reset");
		chk(|level_out, 1'b0, "level reset");
		rd(4'h0, d);
		chk(d, 16'h003c, "command reset");
		r4 = 4'($urandom);
		wr(4'h0, {8'h00, 2'b01, r4, 2'b11});
		chk(range_x4_out, r4, "range write");
		rd(4'h0, d);
		chk(host.oe_seen, 1'b1, "output enabled");
		chk(d, {8'h00, 2'b00, r4, 2'b00}, "command readback");
		wr(4'h0, 16'h00bc);
		rd(4'h0, d);
		chk(host.oe_seen, 1'b0, "output disabled");
		wr(4'h0, 16'h003c);
		for (int i = 0; i < 6; i++)
		begin
			v = (i < 5) ? 5'(1 << i) : 5'h00;
			wr(4'h1, {v, 11'h7ff});
			chk(monitor_sel_out, v, "monitor select");
			chk(monitor_oe_out, v != 5'h00, "monitor enable");
			rd(4'h1, d);
			chk(d, {v, 11'h000}, "monitor readback");
		end
		for (int b = 0; b < 2; b++)
		begin
			bipolar_in <= b[0];
			for (int n = 0; n < 4; n++)
			begin
				nw[n] = (n == 0) ? 14'h2000 : (n == 3) ? 14'h1fff : 14'($urandom);
				zt[n] = (n == 1) ? 9'h100 : 9'($urandom);
				wr(4'(4 + n), {nw[n], 2'b11});
				wr(4'(8 + n), {7'h7f, zt[n]});
				levels;
			end
			wr(4'h0, 16'h403c);
			lat = nw;
			levels;
		end
		code = 14'($urandom);
		nw[2] = ~code;
		wr(4'h5, {code, 2'b11});
		wr(4'h6, {nw[2], 2'b00});
		rd(4'h5, d);
		chk(d, {code, 2'b00}, "input readback");
		wr(4'h0, 16'h803c);
		rd(4'h5, d);
		chk(d, {lat[1], 2'b00}, "latch readback");
		levels;
		latch_load_pin_n_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		latch_load_pin_n_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		lat[1] = code;
		lat[2] = nw[2];
		levels;
		wr(4'h0, 16'h2000);
		chk(range_x4_out, 4'hf, "soft reset range");
		chk(|level_out, 1'b0, "soft reset level");
		rd(4'h8, d);
		chk(d, 16'h0000, "soft reset trim");
		tally_and_finish;
	end
	initial
	begin
		#1500000;
		errors++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
